// ---- hdl/acmc_regs.vh ----
// Register offsets, field positions, reset values and timing counts
// for the comparator measure control block.
// Assumes a 100 MHz clock and APB byte addresses in PADDR[11:0].
`ifndef ACMC_REGS_VH
`define ACMC_REGS_VH

// Register byte offsets.
`define ACMC_OFS_CTRL    12'h000
`define ACMC_OFS_TRIG    12'h004
`define ACMC_OFS_EVR     12'h008
`define ACMC_OFS_INTEN   12'h00c
`define ACMC_OFS_INTFLAG 12'h010
`define ACMC_OFS_STATUS  12'h014
`define ACMC_OFS_WINDOW_CONTROL 12'h018
`define ACMC_OFS_CC0     12'h020
`define ACMC_OFS_CC1     12'h024
`define ACMC_OFS_DIV0    12'h028
`define ACMC_OFS_DIV1    12'h02c

// Control register fields.
`define ACMC_CTRL_EN     0
`define ACMC_CTRL_SWRST  1

// Comparator control fields.
`define ACMC_CC_EN       0
`define ACMC_CC_SINGLE   1
`define ACMC_CC_ISEL     4:3
`define ACMC_CC_PSEL     9:8
`define ACMC_CC_MSEL     14:12
`define ACMC_CC_HYSTON   16
`define ACMC_CC_HYSTLV   18:17

// Event routing fields.
`define ACMC_EVR_CMPO    1:0
`define ACMC_EVR_WINO    2
`define ACMC_EVR_TRGI    5:4

// Window control fields.
`define ACMC_WIN_EN      0
`define ACMC_WIN_ISEL    2:1

// Minus input code that selects the supply divider.
`define ACMC_MSEL_DIV    3'h5

// Reset values.
`define ACMC_CC_RST      19'h00000
`define ACMC_DIV_RST     6'h00

// Timing.
`define ACMC_CLK_MHZ     100
`define ACMC_STARTUP_NS  1000
`define ACMC_STARTUP_CYC \
    ((`ACMC_STARTUP_NS * `ACMC_CLK_MHZ + 999) / 1000)

`endif

// ---- hdl/acmc_chan.v ----
// One comparator channel: start-up wait, sampling and edge conditions.
// Assumes smp is already synchronised to clk and start is a one-cycle
// pulse on clk.
`include "acmc_regs.vh"

module acmc_chan (
    input  wire       clk,
    input  wire       srst,
    input  wire       ce,
    input  wire       en,
    input  wire       single,
    input  wire       start,
    input  wire       smp,
    input  wire [1:0] irq_condition_select,
    output reg        ana_on_q,
    output reg        level_q,
    output reg        done_q,
    output reg        upd_q,
    output reg        irq_q,
    output wire       busy
);

    // One-hot channel states.
    localparam [3:0] S_OFF  = 4'h1;
    localparam [3:0] S_WARM = 4'h2;
    localparam [3:0] S_RUN  = 4'h4;
    localparam [3:0] S_IDLE = 4'h8;
    localparam integer STUP_N = `ACMC_STARTUP_CYC - 1;
    localparam [7:0] STUP_LAST = STUP_N[7:0];

    reg [3:0] st_q;   // Channel state.
    reg [7:0] cnt_q;  // Start-up cycle counter.

    // A sample is taken at the end of start-up and on every cycle after it
    // in continuous mode.
    wire warm_end = (st_q == S_WARM) && (cnt_q == STUP_LAST);
    wire take     = en && (warm_end || (st_q == S_RUN));
    wire rise     = take && smp && !level_q;
    wire fall     = take && !smp && level_q;
    reg  cond;

    assign busy = (st_q == S_WARM);

    // Interrupt condition chosen by the select field.
    always @*
    begin
        case (irq_condition_select)
            2'h0:    cond = rise | fall; // RQ3
            2'h1:    cond = rise;
            2'h2:    cond = fall;
            default: cond = take && warm_end;
        endcase
    end

    // State sequencing; leaving the enable always drops to off.
    always @(posedge clk)
    begin
        if (srst)
        begin
            st_q     <= S_OFF;
            cnt_q    <= 8'h00;
            ana_on_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!en)
            begin
                st_q     <= S_OFF;
                ana_on_q <= 1'b0;
            end
            else
            begin
                case (st_q)
                    S_OFF:
                    begin
                        // Single-shot idles with the analog part off.
                        if (single)
                            st_q <= S_IDLE; // RQ8
                        else
                        begin
                            st_q     <= S_WARM; // RQ2
                            ana_on_q <= 1'b1;
                            cnt_q    <= 8'h00;
                        end
                    end
                    S_WARM:
                    begin
                        if (warm_end)
                        begin
                            // In continuous mode only the first comparison waits.
                            st_q     <= single ? S_IDLE : S_RUN; // RQ5
                            ana_on_q <= !single;
                        end
                        else
                            cnt_q <= cnt_q + 8'h01;
                    end
                    S_RUN:
                        st_q <= S_RUN; // RQ1
                    S_IDLE:
                    begin
                        // A trigger during warm-up is ignored.
                        if (start)
                        begin
                            st_q     <= S_WARM; // RQ12
                            ana_on_q <= 1'b1;
                            cnt_q    <= 8'h00;
                        end
                    end
                    default:
                        st_q <= S_OFF;
                endcase
            end
        end
    end

    // Result, ready bit and condition pulses. The level only moves on a
    // taken sample, so edges compare against the previous measurement.
    always @(posedge clk)
    begin
        if (srst)
        begin
            level_q <= 1'b0;
            done_q  <= 1'b0;
            upd_q   <= 1'b0;
            irq_q   <= 1'b0;
        end
        else if (ce)
        begin
            upd_q <= take;
            irq_q <= cond; // RQ6 RQ11
            if (!en)
                done_q <= 1'b0;
            else if (take)
            begin
                level_q <= smp; // RQ1
                done_q  <= 1'b1; // RQ5 RQ9
            end
            else if (start && (st_q == S_IDLE))
                done_q <= 1'b0; // RQ9 RQ10
        end
    end

endmodule

// ---- hdl/acmc_top.v ----
// Comparator measure control: APB registers, two comparator channels,
// window logic, events, interrupt request and kernel clock request.
// Assumes CMP_RAW comes straight from the analog comparators and that
// EV_START, SLEEP come from logic on CLK.
//
// Function
// RQ1: Continuous mode keeps latest result in status.
// RQ2: Wait start-up delay; result unavailable meanwhile.
// RQ3: Interrupt on toggle, rise, fall or done.
// RQ4: Output event follows level regardless of enable.
// RQ5: Continuous: after start-up update, ready, keep comparing.
// RQ6: Continuous edges compare current and previous sample.
// RQ7: Sleep continuous: toggles request clock, then release.
// RQ8: Single-shot idles until trigger, one comparison.
// RQ9: Trigger clears ready; completion sets it.
// RQ10: Enabled event input starts own single shot.
// RQ11: Single-shot edges compare consecutive measurement results.
// RQ12: Sleep event shot requests clock, then stops.
// RQ13: Software changes input selects only while disabled.
// RQ14: Plus selects pins; minus adds internal refs.
// RQ15: Logic unit consumption needs setting one or two.
// RQ16: Window mode needs equal single settings.
// RQ17: Window state readable; window interrupt by select.
// RQ18: Window event follows inside state; comparators continue.
// RQ19: Window single-shot: any trigger starts both.
// RQ20: Divider on when minus select five and enabled.
// RQ21: Hysteresis per comparator, continuous mode only.
// RQ22: Request while flag and enable both set.
// RQ23: Window state derived from both comparator results.
//
// The APB register port and the register addresses were chosen for this implementation.
`include "acmc_regs.vh"

module acmc_top (
    input  wire        CLK,
    input  wire        SRST,
    input  wire        CE,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    input  wire [3:0]  PSTRB,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [1:0]  CMP_RAW,
    input  wire [1:0]  EV_START,
    input  wire        SLEEP,
    output reg  [1:0]  EV_COMP,
    output reg         EV_WIN,
    output reg         IRQ,
    output reg         KCLK_REQ,
    output reg  [1:0]  ANA_EN,
    output reg  [3:0]  PLUS_SEL,
    output reg  [5:0]  MINUS_SEL,
    output reg  [1:0]  DIV_EN,
    output reg  [11:0] DIV_LVL,
    output reg  [1:0]  NOISE_MARGIN_LEVEL_EN,
    output reg  [3:0]  NOISE_MARGIN_LEVEL_LVL
);

    // Window state codes.
    localparam [1:0] W_BELOW  = 2'h0;
    localparam [1:0] W_INSIDE = 2'h1;
    localparam [1:0] W_ABOVE  = 2'h2;

    reg         ctrl_en_q;   // Global enable.
    reg         swrst_q;     // Software reset pulse.
    reg  [5:0]  evr_q;       // Event routing.
    reg  [2:0]  inten_q;     // Interrupt enables.
    reg  [2:0]  flag_q;      // Sticky interrupt flags.
    reg  [2:0]  winctl_q;    // Window control.
    reg  [18:0] cc_q [0:1];  // Comparator control words.
    reg  [5:0]  dv_q [0:1];  // Divider levels.
    reg  [1:0]  sync1_q;     // First synchroniser stage.
    reg  [1:0]  sync2_q;     // Second synchroniser stage.
    reg  [1:0]  wprev_q;     // Window state at the last update.
    reg  [31:0] rdata;       // Read mux result.
    reg         hit;         // Address decodes to a register.

    wire        rst = SRST | swrst_q;
    wire        setup = PSEL & ~PENABLE;
    wire        wr = PSEL & PENABLE & PWRITE & PREADY;
    wire [31:0] bmask = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
                         {8{PSTRB[1]}}, {8{PSTRB[0]}}};
    wire [31:0] wd = PWDATA & bmask;
    wire [1:0]  level;
    wire [1:0]  done;
    wire [1:0]  upd;
    wire [1:0]  cirq;
    wire [1:0]  ana_on;
    wire [1:0]  busy;
    wire [1:0]  single;
    wire [1:0]  trig;
    wire        win_en = winctl_q[`ACMC_WIN_EN];
    // Window pairing relies on both channels sharing the single setting.
    wire        win_single = win_en & single[0] & single[1]; // RQ16

    // Any trigger starts both channels in window single-shot mode.
    wire [1:0]  start = win_single ? {2{|trig}} : trig; // RQ19

    // Window classification: both low is below, both high is above,
    // and a split means the shared input sits between the two limits.
    wire [1:0]  wstate = (level == 2'b00) ? W_BELOW :
                         (level == 2'b11) ? W_ABOVE : W_INSIDE; // RQ23
    wire        wchg = win_en & (|upd) & (wstate != wprev_q);
    reg         wirq;

    // Window interrupt condition from the select field.
    always @*
    begin
        case (winctl_q[`ACMC_WIN_ISEL])
            2'h0:    wirq = wchg & (wstate == W_ABOVE); // RQ17
            2'h1:    wirq = wchg & (wstate == W_INSIDE);
            2'h2:    wirq = wchg & (wstate == W_BELOW);
            default: wirq = wchg & (wprev_q == W_INSIDE);
        endcase
    end

    // Comparator outputs are asynchronous; two stages before any use.
    always @(posedge CLK)
    begin
        if (SRST)
        begin
            sync1_q <= 2'b00;
            sync2_q <= 2'b00;
        end
        else if (CE)
        begin
            sync1_q <= CMP_RAW;
            sync2_q <= sync1_q;
        end
    end

    // Per-channel registers, triggers and channel logic.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_ch
            wire [11:0] cc_ofs = (i == 0) ? `ACMC_OFS_CC0 : `ACMC_OFS_CC1;
            wire [11:0] dv_ofs = (i == 0) ? `ACMC_OFS_DIV0 : `ACMC_OFS_DIV1;

            assign single[i] = cc_q[i][`ACMC_CC_SINGLE];
            // Software trigger or routed event; only matters in single.
            assign trig[i] = single[i] &
                ((wr & (PADDR == `ACMC_OFS_TRIG) & wd[i]) | // RQ8
                 (EV_START[i] & evr_q[4 + i])); // RQ10

            // Control and divider words.
            always @(posedge CLK)
            begin
                if (rst)
                begin
                    cc_q[i] <= `ACMC_CC_RST;
                    dv_q[i] <= `ACMC_DIV_RST;
                end
                else if (CE && wr)
                begin
                    if (PADDR == cc_ofs)
                        cc_q[i] <= (cc_q[i] & ~bmask[18:0]) | wd[18:0];
                    else if (PADDR == dv_ofs)
                        dv_q[i] <= (dv_q[i] & ~bmask[5:0]) | wd[5:0];
                end
            end

            acmc_chan u_chan (
                .clk      (CLK),
                .srst     (rst),
                .ce       (CE),
                .en       (ctrl_en_q & cc_q[i][`ACMC_CC_EN]),
                .single   (single[i]),
                .start    (start[i]),
                .smp      (sync2_q[i]),
                .irq_condition_select   (cc_q[i][`ACMC_CC_ISEL]),
                .ana_on_q (ana_on[i]),
                .level_q  (level[i]),
                .done_q   (done[i]),
                .upd_q    (upd[i]),
                .irq_q    (cirq[i]),
                .busy     (busy[i])
            );

            // Analog-side controls, all registered.
            always @(posedge CLK)
            begin
                if (rst)
                begin
                    ANA_EN[i]           <= 1'b0;
                    PLUS_SEL[2*i+1:2*i] <= 2'h0;
                    MINUS_SEL[3*i+2:3*i] <= 3'h0;
                    DIV_EN[i]           <= 1'b0;
                    DIV_LVL[6*i+5:6*i]  <= 6'h00;
                    NOISE_MARGIN_LEVEL_EN[i]          <= 1'b0;
                    NOISE_MARGIN_LEVEL_LVL[2*i+1:2*i] <= 2'h0;
                end
                else if (CE)
                begin
                    ANA_EN[i] <= ana_on[i];
                    // Muxes only move while the channel is off, so a
                    // careless write never glitches a live comparison.
                    if (!ana_on[i]) // RQ13
                    begin
                        PLUS_SEL[2*i+1:2*i] <= cc_q[i][`ACMC_CC_PSEL]; // RQ14
                        MINUS_SEL[3*i+2:3*i] <= cc_q[i][`ACMC_CC_MSEL];
                    end
                    DIV_EN[i] <= ana_on[i] & (cc_q[i][`ACMC_CC_MSEL] ==
                                 `ACMC_MSEL_DIV); // RQ20
                    DIV_LVL[6*i+5:6*i] <= dv_q[i];
                    NOISE_MARGIN_LEVEL_EN[i] <= cc_q[i][`ACMC_CC_HYSTON] &
                                  ~single[i]; // RQ21
                    NOISE_MARGIN_LEVEL_LVL[2*i+1:2*i] <= cc_q[i][`ACMC_CC_HYSTLV];
                end
            end
        end
    endgenerate

    // Shared registers and sticky flags; a set wins over a clear.
    always @(posedge CLK)
    begin
        if (rst)
        begin
            ctrl_en_q <= 1'b0;
            evr_q     <= 6'h00;
            inten_q   <= 3'h0;
            flag_q    <= 3'h0;
            winctl_q  <= 3'h0;
            wprev_q   <= W_BELOW;
        end
        else if (CE)
        begin
            if (wr && (PADDR == `ACMC_OFS_CTRL) && PSTRB[0])
                ctrl_en_q <= PWDATA[`ACMC_CTRL_EN];
            else if (wr && (PADDR == `ACMC_OFS_EVR) && PSTRB[0])
                evr_q <= PWDATA[5:0];
            else if (wr && (PADDR == `ACMC_OFS_INTEN) && PSTRB[0])
                inten_q <= PWDATA[2:0];
            else if (wr && (PADDR == `ACMC_OFS_WINDOW_CONTROL) && PSTRB[0])
                winctl_q <= PWDATA[2:0];
            // Write one to clear; fresh conditions override.
            flag_q <= (flag_q & ~((wr && (PADDR == `ACMC_OFS_INTFLAG))
                      ? wd[2:0] : 3'h0)) | {wirq, cirq}; // RQ3 RQ17
            if (win_en && (|upd))
                wprev_q <= wstate;
        end
    end

    // Software reset: one cycle pulse that resets every register except the synchronisers and the pulse register itself.
    always @(posedge CLK)
    begin
        if (SRST)
            swrst_q <= 1'b0;
        else if (CE)
            swrst_q <= wr & (PADDR == `ACMC_OFS_CTRL) & PSTRB[0] &
                       PWDATA[`ACMC_CTRL_SWRST] & ~swrst_q;
    end

    // Events, interrupt request and kernel clock request.
    always @(posedge CLK)
    begin
        if (rst)
        begin
            EV_COMP  <= 2'b00;
            EV_WIN   <= 1'b0;
            IRQ      <= 1'b0;
            KCLK_REQ <= 1'b1;
        end
        else if (CE)
        begin
            // Events ignore interrupt enables.
            EV_COMP <= level & evr_q[`ACMC_EVR_CMPO]; // RQ4
            EV_WIN  <= win_en & evr_q[`ACMC_EVR_WINO] &
                       (wstate == W_INSIDE); // RQ18
            IRQ     <= |(flag_q & inten_q); // RQ22
            // In sleep the clock is wanted only for a warm-up, a pending
            // toggle or a wake-up; otherwise it is released again.
            KCLK_REQ <= ~SLEEP | (|busy) | // RQ12
                        (|((sync2_q ^ level) & ana_on)) | // RQ7
                        (|(flag_q & inten_q));
        end
    end

    // Read mux and address decode.
    always @*
    begin
        rdata = 32'h00000000;
        hit   = 1'b1;
        if (PADDR == `ACMC_OFS_CTRL)
            rdata[`ACMC_CTRL_EN] = ctrl_en_q;
        else if (PADDR == `ACMC_OFS_TRIG)
            rdata = 32'h00000000;
        else if (PADDR == `ACMC_OFS_EVR)
            rdata[5:0] = evr_q;
        else if (PADDR == `ACMC_OFS_INTEN)
            rdata[2:0] = inten_q;
        else if (PADDR == `ACMC_OFS_INTFLAG)
            rdata[2:0] = flag_q;
        else if (PADDR == `ACMC_OFS_STATUS)
            rdata = {22'h000000, done, 2'h0, wstate, 2'h0, level}; // RQ17
        else if (PADDR == `ACMC_OFS_WINDOW_CONTROL)
            rdata[2:0] = winctl_q;
        else if (PADDR == `ACMC_OFS_CC0)
            rdata[18:0] = cc_q[0];
        else if (PADDR == `ACMC_OFS_CC1)
            rdata[18:0] = cc_q[1];
        else if (PADDR == `ACMC_OFS_DIV0)
            rdata[5:0] = dv_q[0];
        else if (PADDR == `ACMC_OFS_DIV1)
            rdata[5:0] = dv_q[1];
        else
            hit = 1'b0;
    end

    // APB answer: data captured at setup, ready for exactly the first
    // access cycle. Status read one cycle early is the price of
    // registered outputs.
    always @(posedge CLK)
    begin
        if (rst)
        begin
            PRDATA  <= 32'h00000000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else if (CE)
        begin
            if (setup)
            begin
                PRDATA  <= PWRITE ? 32'h00000000 : rdata;
                PREADY  <= 1'b1;
                PSLVERR <= ~hit;
            end
            else
            begin
                PREADY  <= 1'b0;
                PSLVERR <= 1'b0;
            end
        end
    end

endmodule

// ---- sim/acmc_top_sva.sv ----
// Checker for the comparator measure control top: bus timing, divider
// gating, interrupt release and kernel clock request.
// Assumes one clock domain, CLK, with synchronous reset SRST.
module acmc_top_sva (
    input logic        CLK,
    input logic        SRST,
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [11:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [3:0]  PSTRB,
    input logic [31:0] PRDATA,
    input logic        PREADY,
    input logic        PSLVERR,
    input logic        SLEEP,
    input logic        IRQ,
    input logic        KCLK_REQ,
    input logic [1:0]  ANA_EN,
    input logic [5:0]  MINUS_SEL,
    input logic [1:0]  DIV_EN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // Setup cycle and completed access of a bus transfer.
    wire setup = PSEL && !PENABLE;
    wire acc   = PSEL && PENABLE && PREADY;
    // Holes in the map: the gap at 0x1c and all above 0x2c.
    wire unmapped = (PADDR > 12'h02c) || (PADDR == 12'h01c);

    property p_ready_next; setup |=> PREADY; endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("ready missing after setup");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held too long");
    property p_err_map; setup |=> PSLVERR == $past(unmapped); endproperty
    a_err_map: assert property (p_err_map)
        else $error("error response wrong for address");
    property p_err_data; PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("refused read returned data");
    property p_trig_zero;
        PREADY && !PWRITE && PADDR == 12'h004 |-> PRDATA == 32'h0;
    endproperty
    a_trig_zero: assert property (p_trig_zero)
        else $error("trigger register read not zero");
    property p_div0; DIV_EN[0] |-> MINUS_SEL[2:0] == 3'h5; endproperty
    a_div0: assert property (p_div0)
        else $error("divider 0 on with other minus select");
    property p_div1; DIV_EN[1] |-> MINUS_SEL[5:3] == 3'h5; endproperty
    a_div1: assert property (p_div1)
        else $error("divider 1 on with other minus select");
    property p_kclk; !SLEEP && $past(SLEEP) == 1'b0 |-> KCLK_REQ;
    endproperty
    a_kclk: assert property (p_kclk)
        else $error("kernel clock dropped while awake");
    property p_irq_off;
        acc && PWRITE && PADDR == 12'h00c && PSTRB[0] &&
        PWDATA[2:0] == 3'h0 |-> ##2 !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("request stays after all enables cleared");
    property p_rst_vals;
        $fell(SRST) |-> !IRQ && ANA_EN == 2'h0 && KCLK_REQ;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs wrong after reset");
    c_err: cover property (PSLVERR);
    c_irq: cover property ($rose(IRQ));
    c_div: cover property ($rose(DIV_EN[1]));
    c_shot: cover property ($fell(ANA_EN[1]));
endmodule

// ---- sim/acmc_far.sv ----
// Far-side model: the two analog comparator outputs and the event
// system's start pulses. Assumes the caller runs on CLK edges.
module acmc_far (
    input  logic       CLK,
    output logic [1:0] CMP_RAW,
    output logic [1:0] EV_START
);
    timeunit 1ns;
    timeprecision 1ps;
    // Comparators start low; no events are pending at power-up.
    initial
    begin
        CMP_RAW = 2'h0;
        EV_START = 2'h0;
    end
    // Move one comparator output just after an edge.
    task automatic lvl(input int i, input logic v);
        @(posedge CLK);
        CMP_RAW[i] <= v;
    endtask
    // An event is a single-cycle pulse, as the event system sends it.
    task automatic ev(input int i);
        @(posedge CLK);
        EV_START[i] <= 1'b1;
        @(posedge CLK);
        EV_START[i] <= 1'b0;
    endtask
endmodule

// ---- sim/acmc_top_tb.sv ----
// Self-checking bench for the comparator measure control top.
// Assumes the register map and warm-up count of acmc_regs.vh.
`include "acmc_regs.vh"
module acmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0;
    logic        SRST = 1'b1;
    logic        CE = 1'b1;
    logic        SLEEP = 1'b0;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0]  PSTRB = 4'hf;
    logic [31:0] PRDATA, rd;
    logic        PREADY, PSLVERR, EV_WIN, IRQ, KCLK_REQ, err;
    logic [1:0]  CMP_RAW, EV_START, EV_COMP, ANA_EN, DIV_EN, NOISE_MARGIN_LEVEL_EN;
    logic [3:0]  PLUS_SEL, NOISE_MARGIN_LEVEL_LVL;
    logic [5:0]  MINUS_SEL;
    logic [11:0] DIV_LVL;
    int          n_errors = 0;
    int          samples_checked = 0;

    acmc_top acmc_top_inst (.*);
    acmc_far acmc_far_inst (.*);
    always #5 CLK = ~CLK;

    // Prints the verdict and ends the run.
    task automatic finish_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Case equality, so an unknown never passes.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // One APB transfer; the request holds until ready is sampled.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1)
        begin
            n_errors++;
            finish_test();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Polls status until all done bits in m are set, with a bound.
    task automatic wait_done(input logic [31:0] m);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `ACMC_OFS_STATUS, 32'h0);
            n++;
        end
        while ((rd & m) !== m && n < 100);
        chk(rd & m, m);
    endtask

    // Reset values, read-back, write-only trigger and a hole in the map.
    task automatic s_regs;
        apb(1'b0, `ACMC_OFS_CC0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `ACMC_OFS_DIV0, 32'h3f);
        apb(1'b0, `ACMC_OFS_DIV0, 32'h0);
        chk(rd, 32'h3f);
        apb(1'b1, `ACMC_OFS_TRIG, 32'h0);
        apb(1'b0, `ACMC_OFS_TRIG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask
    // Continuous channel 0 on a rising-edge interrupt, divider, hysteresis.
    task automatic s_cont;
        apb(1'b1, `ACMC_OFS_EVR, 32'h25);
        apb(1'b1, `ACMC_OFS_INTEN, 32'h1);
        apb(1'b1, `ACMC_OFS_CC0, 32'h55309);
        apb(1'b1, `ACMC_OFS_CTRL, 32'h1);
        apb(1'b0, `ACMC_OFS_STATUS, 32'h0);
        chk(rd[8], 1'b0);
        wait_done(32'h100);
        chk({ANA_EN[0], DIV_EN[0], DIV_LVL[5:0], NOISE_MARGIN_LEVEL_EN[0], NOISE_MARGIN_LEVEL_LVL[1:0],
             PLUS_SEL[1:0], MINUS_SEL[2:0]}, 32'hffdd);
        chk({IRQ, rd[0]}, 2'b00);
        acmc_far_inst.lvl(0, 1'b1);
        repeat (8) @(posedge CLK);
        apb(1'b0, `ACMC_OFS_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b0, `ACMC_OFS_INTFLAG, 32'h0);
        chk({IRQ, EV_COMP[0], rd[2:0]}, 5'h19);
        apb(1'b1, `ACMC_OFS_INTEN, 32'h0);
        apb(1'b1, `ACMC_OFS_INTFLAG, 32'h1);
        chk(IRQ, 1'b0);
        acmc_far_inst.lvl(0, 1'b0);
        repeat (8) @(posedge CLK);
        apb(1'b0, `ACMC_OFS_INTFLAG, 32'h0);
        chk({EV_COMP[0], rd[0]}, 2'b00);
        apb(1'b1, `ACMC_OFS_CC0, 32'h0);
    endtask
    // Single shots on channel 1, one per interrupt select, last by event.
    task automatic s_single;
        logic [3:0] raw;
        logic [3:0] flag;
        raw = 4'b1101;
        flag = 4'b1001;
        for (int i = 0; i < 4; i++)
        begin
            acmc_far_inst.lvl(1, raw[i]);
            apb(1'b1, `ACMC_OFS_CC1, 32'h15003 | (i << 3));
            if (i == 3)
                acmc_far_inst.ev(1);
            else
                apb(1'b1, `ACMC_OFS_TRIG, 32'h2);
            chk({ANA_EN[1], NOISE_MARGIN_LEVEL_EN[1], DIV_EN[1]}, 3'b000);
            apb(1'b0, `ACMC_OFS_STATUS, 32'h0);
            chk({ANA_EN[1], DIV_EN[1], rd[9]}, 3'b110);
            wait_done(32'h200);
            apb(1'b0, `ACMC_OFS_INTFLAG, 32'h0);
            chk({ANA_EN[1], rd[1]}, {1'b0, flag[i]});
            apb(1'b1, `ACMC_OFS_INTFLAG, 32'h2);
        end
    endtask
    // Window pair in single mode: one trigger starts both comparators.
    task automatic s_window;
        apb(1'b1, `ACMC_OFS_CC0, 32'h3);
        apb(1'b1, `ACMC_OFS_WINDOW_CONTROL, 32'h3);
        acmc_far_inst.lvl(0, 1'b1);
        SLEEP <= 1'b1;
        apb(1'b1, `ACMC_OFS_TRIG, 32'h1);
        apb(1'b0, `ACMC_OFS_STATUS, 32'h0);
        chk({KCLK_REQ, rd[9:8]}, 3'h4);
        wait_done(32'h300);
        chk({EV_WIN, rd[5:4]}, 3'h2);
        apb(1'b1, `ACMC_OFS_INTFLAG, 32'h7);
        acmc_far_inst.lvl(0, 1'b0);
        apb(1'b1, `ACMC_OFS_TRIG, 32'h2);
        wait_done(32'h300);
        apb(1'b0, `ACMC_OFS_STATUS, 32'h0);
        chk({EV_WIN, rd[5:4]}, 3'h5);
        apb(1'b0, `ACMC_OFS_INTFLAG, 32'h0);
        chk(rd[2], 1'b1);
    endtask
    // Software reset returns the registers to their reset values.
    task automatic s_swrst;
        apb(1'b1, `ACMC_OFS_CTRL, 32'h2);
        apb(1'b0, `ACMC_OFS_CC1, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `ACMC_OFS_WINDOW_CONTROL, 32'h0);
        chk(rd, 32'h0);
    endtask

    // Main sequence: reset for ten cycles, then every scenario in turn.
    initial
    begin
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        s_regs();
        s_cont();
        s_single();
        s_window();
        s_swrst();
        finish_test();
    end
endmodule

bind acmc_top acmc_top_sva acmc_top_sva_inst (.*);
